// file: src/cpg_pkg.sv
// Constants and carriers for generic channel program op execution
package cpg_pkg;
  // ==========================================
  // Opcodes
  // ==========================================
  localparam logic [3:0] GENERIC_GROUP = 4'h0;
  localparam logic [7:0] NO_OPERATION_OP = 8'h00;
  localparam logic [7:0] WAIT_OP = 8'h01;
  localparam logic [7:0] NEXT_BLOCK_OP = 8'h02;
  localparam logic [7:0] SYNC_SEARCH_OP = 8'h03;
  localparam logic [7:0] BLOCK_CHECK_OP = 8'h04;
  localparam logic [7:0] DECREMENT_OP = 8'h05;
  localparam logic [7:0] SUBROUTINE_RETURN_OP = 8'h06;
  localparam logic [7:0] SHIFT_RIGHT_OP = 8'h07;
  localparam logic [7:0] HOST_INTERRUPT_OP = 8'h08;
  localparam logic [7:0] SOFT_INITIALIZE_OP = 8'h09;
  // ==========================================
  // Line table offsets within a channel half
  // ==========================================
  localparam logic [4:0] LT_CRC_LO = 5'h04;
  localparam logic [4:0] LT_CRC_HI = 5'h05;
  localparam logic [4:0] LT_STAT1 = 5'h10;
  localparam logic [4:0] LT_STAT2 = 5'h11;
  localparam logic [4:0] LT_RET_HI = 5'h12;
  localparam logic [4:0] LT_RET_LO = 5'h13;
  localparam logic [4:0] LT_CTX_PCH = 5'h14;
  localparam logic [4:0] LT_CTX_PCL = 5'h15;
  localparam logic [4:0] LT_CTX_R = 5'h16;
  localparam logic [4:0] LT_CTX_IND = 5'h17;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // Interrupt flag is the leftmost control bit
  localparam int CCB_IRQ_BIT = 7;
  localparam logic [11:0] CALL_LEN = 12'h002;
  // ==========================================
  // Register map
  // ==========================================
  localparam logic [11:0] REG_IRQ_STAT = 12'h000;
  localparam logic [11:0] REG_IRQ_MASK = 12'h004;
  localparam logic [11:0] REG_INT_LEVEL = 12'h008;
  localparam logic [11:0] REG_STATE = 12'h00C;
  localparam logic [11:0] REG_CCB_BASE = 12'h100;
  localparam logic [11:0] REG_LT_BASE = 12'h400;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0;
  localparam logic [31:0] INT_LEVEL_RST = 32'h0;
  // ==========================================
  // Types
  // ==========================================
  typedef enum logic [2:0] {
    K_GENERIC, K_RESUME, K_CALL, K_BRANCH, K_JUMP, K_LT_READ
  } cpg_kind_e;
  typedef enum logic {S_IDLE, S_EXEC} cpg_state_e;
  typedef struct packed {
    logic valid;
    cpg_kind_e kind;
    logic [7:0] opcode;
    logic [3:0] chan;
    logic [11:0] pc;
    logic [7:0] r;
    logic [3:0] ind;
    logic [12:0] disp;
    logic [5:0] lt_byte;
  } cpg_req_s;
  typedef struct packed {
    logic done;
    logic free;
    logic bad;
    logic [11:0] pc;
    logic [7:0] r;
    logic [3:0] ind;
  } cpg_res_s;
endpackage : cpg_pkg

// file: src/cpg_generic_ops.sv
// Generic opcode execution unit of the channel program engine
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module cpg_generic_ops #(
  parameter int NCH = 4,
  parameter int CCB_PER_CH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire cpg_pkg::cpg_req_s req,
  output logic req_ready,
  output cpg_pkg::cpg_res_s res,
  input wire logic [NCH-1:0] line_req,
  input wire logic [NCH-1:0] sync_det,
  output logic [NCH-1:0] chan_req,
  output logic [NCH-1:0] hunt_start,
  output logic soft_init
);
  import cpg_pkg::*;

  localparam int CH_W = $clog2(NCH);
  localparam int LT_W = CH_W + 5;
  localparam int LT_N = NCH * 32;
  localparam int NCCB = NCH * CCB_PER_CH;
  localparam int CI_W = $clog2(NCCB);
  localparam int CB_W = (CCB_PER_CH > 1) ? $clog2(CCB_PER_CH) : 1;

  // ==========================================
  // Parameter check
  // ==========================================
  generate
    if (NCH < 2 || NCH > 16 || (1 << CH_W) != NCH || CCB_PER_CH < 1 || NCCB > 192) begin : g_bad
      $error("cpg_generic_ops: unsupported channel or block count");
    end
  endgenerate

  // ==========================================
  // State
  // ==========================================
  logic [7:0] lt_ff [LT_N];
  logic [7:0] ccb_ctl_ff [NCCB];
  logic [15:0] ccb_stat_ff [NCCB];
  logic [NCCB-1:0] ccb_done_ff;
  logic [CB_W-1:0] ccb_ptr_ff [NCH];
  cpg_state_e state_ff;
  cpg_req_s req_ff;
  cpg_res_s res_ff;
  logic ready_ff;
  logic [NCH:0] irq_stat_ff;
  logic [NCH:0] irq_mask_ff;
  logic [2*NCH-1:0] int_lvl_ff;
  logic [NCH-1:0] hunt_ff;
  logic [NCH-1:0] hunt_start_ff;
  logic [NCH-1:0] chan_req_ff;
  logic soft_init_ff;
  logic irq_ff;
  logic waitreq_ff;
  logic [31:0] rdata_ff;

  // ==========================================
  // Helpers
  // ==========================================
  function automatic logic [LT_W-1:0] lti(input logic [3:0] c, input logic [4:0] o);
    lti = {c[CH_W-1:0], o};
  endfunction : lti

  // Residue update, one data bit at a time, low bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int b = 0; b < 8; b++) begin
      x = (x[0] ^ d[b]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    crc_byte = x;
  endfunction : crc_byte

  logic exec;
  logic gen_op;
  logic [CH_W-1:0] ch;
  logic is_tx;
  logic [CI_W-1:0] cur_idx;
  logic lvl_ok;
  logic [15:0] crc_nxt;
  logic [11:0] ret_pc;
  logic [11:0] call_ret;
  logic [LT_W-1:0] rd_idx;

  assign exec = (state_ff == S_EXEC);
  // Generic group lives in the zero upper nibble
  assign gen_op = exec && req_ff.kind == K_GENERIC && req_ff.opcode[7:4] == GENERIC_GROUP;
  assign ch = req_ff.chan[CH_W-1:0];
  // Odd channels face the transmit half of a line
  assign is_tx = ch[0];
  assign cur_idx = CI_W'(int'(ch) * CCB_PER_CH + int'(ccb_ptr_ff[ch]));
  assign lvl_ok = int_lvl_ff[2*ch +: 2] != 2'h0;
  assign crc_nxt = crc_byte({lt_ff[lti(req_ff.chan, LT_CRC_HI)], lt_ff[lti(req_ff.chan, LT_CRC_LO)]}, req_ff.r);
  assign ret_pc = {lt_ff[lti(req_ff.chan, LT_RET_HI)][3:0], lt_ff[lti(req_ff.chan, LT_RET_LO)]};
  assign call_ret = req_ff.pc + CALL_LEN;
  // Whole 64-byte line table of the channel's line
  assign rd_idx = LT_W'(int'(ch >> 1) * 64 + int'(req_ff.lt_byte));

  function automatic logic op_hit(input logic [7:0] o);
    op_hit = gen_op && req_ff.opcode == o;
  endfunction : op_hit

  // ==========================================
  // Bus decode
  // ==========================================
  logic bus_req;
  logic bus_wr;
  logic [11:0] lt_off;
  logic [11:0] cb_off;
  logic lt_hit;
  logic cb_hit;
  logic [LT_W-1:0] bus_lti;
  logic [CI_W-1:0] bus_cbi;

  // Only the first cycle of a held request counts
  assign bus_req = (avs_read || avs_write) && waitreq_ff;
  assign bus_wr = avs_write && !waitreq_ff; // Write lands one edge after the answer, on the edge where waitrequest is seen low
  assign lt_off = avs_address - REG_LT_BASE;
  assign cb_off = avs_address - REG_CCB_BASE;
  assign lt_hit = avs_address >= REG_LT_BASE && int'(lt_off[11:2]) < LT_N;
  assign cb_hit = avs_address >= REG_CCB_BASE && avs_address < REG_LT_BASE && int'(cb_off[11:2]) < NCCB;
  assign bus_lti = lt_off[LT_W+1:2];
  assign bus_cbi = cb_off[CI_W+1:2];

  // ==========================================
  // Sequencer and results
  // ==========================================
  // Each request takes one execute cycle; done and free pulse once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= S_IDLE;
      req_ff <= '0;
      res_ff <= '0;
      ready_ff <= 1'b1;
    end else begin
      res_ff.done <= 1'b0;
      res_ff.free <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (req.valid) begin
            req_ff <= req;
            state_ff <= S_EXEC;
            ready_ff <= 1'b0;
          end
        end
        S_EXEC: begin
          state_ff <= S_IDLE;
          ready_ff <= 1'b1;
          res_ff.done <= 1'b1;
          res_ff.bad <= 1'b0;
          res_ff.pc <= req_ff.pc + 12'h001;
          res_ff.r <= req_ff.r;
          res_ff.ind <= req_ff.ind;
          case (req_ff.kind)
            K_GENERIC: begin
              if (!gen_op) begin
                res_ff.bad <= 1'b1;
              end else begin
                case (req_ff.opcode)
                  WAIT_OP: res_ff.free <= 1'b1;
                  DECREMENT_OP: res_ff.r <= req_ff.r - 8'h01;
                  SHIFT_RIGHT_OP: res_ff.r <= {1'b0, req_ff.r[7:1]};
                  SUBROUTINE_RETURN_OP: res_ff.pc <= ret_pc;
                  NO_OPERATION_OP, NEXT_BLOCK_OP, SYNC_SEARCH_OP, BLOCK_CHECK_OP,
                  HOST_INTERRUPT_OP, SOFT_INITIALIZE_OP: res_ff.bad <= 1'b0;
                  default: res_ff.bad <= 1'b1;
                endcase
              end
            end
            K_RESUME: begin
              // Context comes back from the channel's table half
              res_ff.pc <= {lt_ff[lti(req_ff.chan, LT_CTX_PCH)][3:0], lt_ff[lti(req_ff.chan, LT_CTX_PCL)]};
              res_ff.r <= lt_ff[lti(req_ff.chan, LT_CTX_R)];
              res_ff.ind <= lt_ff[lti(req_ff.chan, LT_CTX_IND)][3:0];
            end
            // Eight-bit signed field bounds the short reach
            K_CALL, K_BRANCH: res_ff.pc <= req_ff.pc + {{4{req_ff.disp[7]}}, req_ff.disp[7:0]};
            // Thirteen-bit reach wraps modulo the 12-bit space
            K_JUMP: res_ff.pc <= req_ff.pc + req_ff.disp[11:0];
            K_LT_READ: res_ff.r <= lt_ff[rd_idx];
            default: res_ff.bad <= 1'b1;
          endcase
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // Line table
  // ==========================================
  // Engine writes follow bus writes so the engine wins a clash
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LT_N; i++) begin
        lt_ff[i] <= 8'h00;
      end
    end else begin
      if (bus_wr && lt_hit) begin
        lt_ff[bus_lti] <= avs_writedata[7:0];
      end
      if (op_hit(WAIT_OP)) begin
        lt_ff[lti(req_ff.chan, LT_CTX_PCH)] <= {4'h0, req_ff.pc[11:8]};
        lt_ff[lti(req_ff.chan, LT_CTX_PCL)] <= req_ff.pc[7:0];
        lt_ff[lti(req_ff.chan, LT_CTX_R)] <= req_ff.r;
        lt_ff[lti(req_ff.chan, LT_CTX_IND)] <= {4'h0, req_ff.ind};
      end
      if (op_hit(BLOCK_CHECK_OP)) begin
        lt_ff[lti(req_ff.chan, LT_CRC_LO)] <= crc_nxt[7:0];
        lt_ff[lti(req_ff.chan, LT_CRC_HI)] <= crc_nxt[15:8];
      end
      if (exec && req_ff.kind == K_CALL) begin
        lt_ff[lti(req_ff.chan, LT_RET_HI)] <= {4'h0, call_ret[11:8]};
        lt_ff[lti(req_ff.chan, LT_RET_LO)] <= call_ret[7:0];
      end
    end
  end

  // ==========================================
  // Control blocks
  // ==========================================
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NCCB; i++) begin
        ccb_ctl_ff[i] <= 8'h00;
        ccb_stat_ff[i] <= 16'h0000;
      end
      for (int i = 0; i < NCH; i++) begin
        ccb_ptr_ff[i] <= '0;
      end
      ccb_done_ff <= '0;
    end else begin
      // Host rearms a block by writing its control byte
      if (bus_wr && cb_hit) begin
        ccb_ctl_ff[bus_cbi] <= avs_writedata[7:0];
        ccb_done_ff[bus_cbi] <= 1'b0;
      end
      if (op_hit(NEXT_BLOCK_OP)) begin
        ccb_stat_ff[cur_idx] <= {lt_ff[lti(req_ff.chan, LT_STAT1)], lt_ff[lti(req_ff.chan, LT_STAT2)]};
        ccb_done_ff[cur_idx] <= 1'b1;
        ccb_ctl_ff[cur_idx] <= 8'h00;
        // List is circular per channel
        ccb_ptr_ff[ch] <= (int'(ccb_ptr_ff[ch]) == CCB_PER_CH - 1) ? '0 : ccb_ptr_ff[ch] + 1'b1;
      end
    end
  end

  // ==========================================
  // Host interrupts
  // ==========================================
  logic [NCH:0] irq_evt;
  logic [NCH:0] irq_clr;

  // Top bit flags a soft initialize
  always_comb begin
    irq_evt = '0;
    irq_evt[ch] = lvl_ok && (op_hit(HOST_INTERRUPT_OP)
      || (op_hit(NEXT_BLOCK_OP) && ccb_ctl_ff[cur_idx][CCB_IRQ_BIT]));
    irq_evt[NCH] = op_hit(SOFT_INITIALIZE_OP);
  end
  assign irq_clr = (bus_wr && avs_address == REG_IRQ_STAT) ? avs_writedata[NCH:0] : '0;

  // Set beats clear so a same-cycle event is kept
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST[NCH:0];
      int_lvl_ff <= INT_LEVEL_RST[2*NCH-1:0];
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
      if (bus_wr && avs_address == REG_IRQ_MASK) begin
        irq_mask_ff <= avs_writedata[NCH:0];
      end
      if (bus_wr && avs_address == REG_INT_LEVEL) begin
        int_lvl_ff <= avs_writedata[2*NCH-1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ==========================================
  // Bus answer
  // ==========================================
  // Fixed one-cycle answer keeps the slave simple
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitreq_ff <= 1'b1;
      rdata_ff <= 32'h0;
    end else begin
      waitreq_ff <= !bus_req;
      if (bus_req && avs_read) begin
        rdata_ff <= 32'h0;
        if (avs_address == REG_IRQ_STAT) rdata_ff <= 32'(irq_stat_ff);
        if (avs_address == REG_IRQ_MASK) rdata_ff <= 32'(irq_mask_ff);
        if (avs_address == REG_INT_LEVEL) rdata_ff <= 32'(int_lvl_ff);
        if (avs_address == REG_STATE) rdata_ff <= {15'h0, ready_ff, 16'(hunt_ff)};
        if (cb_hit) rdata_ff <= {7'h0, ccb_done_ff[bus_cbi], ccb_stat_ff[bus_cbi], ccb_ctl_ff[bus_cbi]};
        if (lt_hit) rdata_ff <= {24'h0, lt_ff[bus_lti]};
      end
    end
  end

  // ==========================================
  // Sync hunt and channel requests
  // ==========================================
  logic sinit_now;
  assign sinit_now = op_hit(SOFT_INITIALIZE_OP);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_init_ff <= 1'b0;
    end else begin
      soft_init_ff <= sinit_now;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic hunt_set;
      // Transmit channels ignore the search
      assign hunt_set = op_hit(SYNC_SEARCH_OP) && !is_tx && int'(ch) == gi;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          hunt_ff[gi] <= 1'b0;
          hunt_start_ff[gi] <= 1'b0;
          chan_req_ff[gi] <= 1'b0;
        end else begin
          hunt_start_ff[gi] <= hunt_set;
          // Soft initialize drops every hunt
          hunt_ff[gi] <= !sinit_now && (hunt_set || (hunt_ff[gi] && !sync_det[gi]));
          // Requests stay masked while hunting
          chan_req_ff[gi] <= line_req[gi] && !sinit_now && !hunt_set && !(hunt_ff[gi] && !sync_det[gi]);
        end
      end
    end
  endgenerate

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign irq = irq_ff;
  assign req_ready = ready_ff;
  assign res = res_ff;
  assign chan_req = chan_req_ff;
  assign hunt_start = hunt_start_ff;
  assign soft_init = soft_init_ff;

  // ==========================================
  // Checks
  // ==========================================
  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_bus_req;
    (avs_read || avs_write) && waitreq_ff;
  endsequence
  sequence s_bus_ack;
    !waitreq_ff ##1 waitreq_ff;
  endsequence
  sequence s_sinit_pulse;
    soft_init_ff && hunt_ff == '0 ##1 !soft_init_ff;
  endsequence

  chk_bus_answer: assert property (s_bus_req |=> s_bus_ack)
    else $error("Bus answer not one cycle after request");
  chk_nop_advance: assert property (
    gen_op && req_ff.opcode == NO_OPERATION_OP |=> res_ff.done && res_ff.pc == $past(req_ff.pc) + 12'h001
      && res_ff.r == $past(req_ff.r) && res_ff.ind == $past(req_ff.ind))
    else $error("No-op altered state");
  chk_wait_save: assert property (
    gen_op && req_ff.opcode == WAIT_OP |=> res_ff.free && lt_ff[lti($past(req_ff.chan), LT_CTX_R)] == $past(req_ff.r))
    else $error("Wait did not save context");
  chk_gnb_block: assert property (
    gen_op && req_ff.opcode == NEXT_BLOCK_OP |=> ccb_done_ff[$past(cur_idx)] && ccb_ctl_ff[$past(cur_idx)] == 8'h00)
    else $error("Block not completed");
  chk_sync_hunt: assert property (
    gen_op && req_ff.opcode == SYNC_SEARCH_OP && !is_tx |=> hunt_start_ff[$past(ch)] && hunt_ff[$past(ch)])
    else $error("Hunt not started");
  chk_hunt_gate: assert property (
    1'b1 |=> (chan_req_ff & $past(hunt_ff) & ~$past(sync_det)) == '0)
    else $error("Request while hunting");
  chk_dec_value: assert property (
    gen_op && req_ff.opcode == DECREMENT_OP |=> res_ff.r == $past(req_ff.r) - 8'h01)
    else $error("Decrement wrong");
  chk_ret_pc: assert property (
    gen_op && req_ff.opcode == SUBROUTINE_RETURN_OP |=> res_ff.pc == $past(ret_pc))
    else $error("Return address wrong");
  chk_shift_right: assert property (
    gen_op && req_ff.opcode == SHIFT_RIGHT_OP |=> res_ff.r == ($past(req_ff.r) >> 1))
    else $error("Shift right wrong");
  chk_host_interrupt_op_sets: assert property (
    gen_op && req_ff.opcode == HOST_INTERRUPT_OP && lvl_ok |=> irq_stat_ff[$past(ch)]
      ##1 (irq_ff || !irq_mask_ff[$past(ch, 2)]))
    else $error("Interrupt op lost");
  chk_sinit_halt: assert property (
    sinit_now |=> s_sinit_pulse)
    else $error("Soft initialize not applied");
  chk_call_store: assert property (
    exec && req_ff.kind == K_CALL |=> ret_pc == $past(call_ret))
    else $error("Return address not stored");
endmodule : cpg_generic_ops
`default_nettype wire

// file: dv/cpg_host_model.sv
// Host side register master for the generic op unit
`timescale 1ns/1ns
`default_nettype none
module cpg_host_model (
  input wire logic clk,
  output logic [11:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // ==========
  // Bus cycles
  // ==========
  // Idle bus from time zero
  initial begin
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // One cycle; held until waitrequest is sampled low, the bench watchdog ends a hang
  task automatic cyc(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    cyc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    cyc(1'b0, a, 32'h0, q);
  endtask : rd
endmodule : cpg_host_model
`default_nettype wire

// file: dv/cpg_generic_ops_tb.sv
// Self-checking bench for the generic op unit
`timescale 1ns/1ns
`default_nettype none
module cpg_generic_ops_tb;
  import cpg_pkg::*;
  // ==========
  // Signals
  // ==========
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, irq, req_ready, soft_init, si;
  logic [11:0] avs_address, pcv;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] line_req, sync_det, chan_req, hunt_start, hs;
  logic [7:0] rv, op;
  logic [15:0] crc;
  logic [7:0] ops [3] = '{NO_OPERATION_OP, DECREMENT_OP, SHIFT_RIGHT_OP};
  cpg_req_s req;
  cpg_res_s res;
  int miscompares, checks, seed, i;
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  cpg_generic_ops #(.NCH(4), .CCB_PER_CH(2)) u_cpg_generic_ops (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .req(req),
    .req_ready(req_ready), .res(res), .line_req(line_req), .sync_det(sync_det), .chan_req(chan_req),
    .hunt_start(hunt_start), .soft_init(soft_init));
  cpg_host_model u_host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // ==========
  // Reference model
  // ==========
  function automatic logic [7:0] alu(input logic [7:0] o, input logic [7:0] r);
    case (o)
      DECREMENT_OP: return r - 8'h01;
      SHIFT_RIGHT_OP: return {1'b0, r[7:1]};
      default: return r;
    endcase
  endfunction : alu
  // Reflected CRC-16, one byte, low bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_step
  function automatic logic [11:0] lta(input int ch, input int off);
    return 12'(32'h400 + (ch * 32 + off) * 4);
  endfunction : lta
  // ==========
  // Tasks
  // ==========
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One request, then wait for the result pulse; pulses of the same cycle are caught too
  task automatic ex(input cpg_kind_e k, input logic [7:0] o, input logic [3:0] ch, input logic [11:0] pc,
    input logic [7:0] r, input logic [12:0] disp);
    int n;
    @(posedge clk);
    req <= '{1'b1, k, o, ch, pc, r, 4'hA, disp, 6'h3F};
    @(posedge clk);
    req.valid <= 1'b0;
    n = 0;
    hs = 4'h0;
    si = 1'b0;
    while (res.done !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    hs = hunt_start;
    si = soft_init;
  endtask : ex
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  // ==========
  // Main sequence
  // ==========
  initial begin
    rst_b = 1'b0;
    req = '0;
    line_req = 4'h0;
    sync_det = 4'h0;
    seed = 12;
    repeat (12) @(posedge clk);
    chk("ready_rst", 32'h1, {31'h0, req_ready});
    rst_b <= 1'b1;
    // Working register ops with random operands
    for (i = 0; i < 12; i++) begin
      op = ops[i % 3];
      rv = $random(seed);
      pcv = $random(seed);
      ex(K_GENERIC, op, 4'h2, pcv, rv, 13'h0000);
      chk("res_r", alu(op, rv), res.r);
      chk("res_pc", pcv + 12'h001, res.pc);
      chk("res_bad", 32'h0, res.bad);
    end
    ex(K_GENERIC, DECREMENT_OP, 4'h0, 12'hFFF, 8'h00, 13'h0000);
    chk("dec_wrap", 32'hFF, res.r);
    // Unknown codes refused
    ex(K_GENERIC, 8'h0A, 4'h0, 12'h000, 8'h00, 13'h0000);
    chk("bad_0a", 32'h1, res.bad);
    ex(K_GENERIC, 8'h10, 4'h0, 12'h000, 8'h00, 13'h0000);
    chk("bad_10", 32'h1, res.bad);
    // Suspend and resume
    ex(K_GENERIC, WAIT_OP, 4'h1, 12'h234, 8'h5C, 13'h0000);
    chk("wait_free", 32'h1, res.free);
    u_host.rd(lta(1, 22), rd);
    chk("ctx_r", 32'h5C, rd);
    ex(K_RESUME, 8'h00, 4'h1, 12'h000, 8'h00, 13'h0000);
    chk("res_pc", 32'h234, res.pc);
    chk("res_r", 32'h5C, res.r);
    chk("res_ind", 32'hA, res.ind);
    chk("res_free", 32'h0, res.free);
    // Call and return on a transmit channel
    ex(K_CALL, 8'h00, 4'h1, 12'h3F0, 8'h00, 13'h0010);
    chk("call_pc", 32'h400, res.pc);
    u_host.rd(lta(1, 18), rd);
    chk("ret_hi", 32'h3, rd);
    u_host.rd(lta(1, 19), rd);
    chk("ret_lo", 32'hF2, rd);
    ex(K_GENERIC, SUBROUTINE_RETURN_OP, 4'h1, 12'h400, 8'h00, 13'h0000);
    chk("ret_pc", 32'h3F2, res.pc);
    // Displacement extremes, then the last byte of a line table
    ex(K_BRANCH, 8'h00, 4'h0, 12'h100, 8'h00, 13'h0080);
    chk("br_min", 32'h080, res.pc);
    ex(K_BRANCH, 8'h00, 4'h0, 12'h100, 8'h00, 13'h007F);
    chk("br_max", 32'h17F, res.pc);
    ex(K_JUMP, 8'h00, 4'h0, 12'h100, 8'h00, 13'h0FFF);
    chk("jmp_max", 32'h0FF, res.pc);
    ex(K_JUMP, 8'h00, 4'h0, 12'h100, 8'h00, 13'h1000);
    chk("jmp_min", 32'h100, res.pc);
    u_host.wr(12'h4FC, 32'hA5);
    ex(K_LT_READ, 8'h00, 4'h0, 12'h000, 8'h00, 13'h0000);
    chk("lt_63", 32'hA5, res.r);
    // Host interrupt op, level zero suppresses
    u_host.wr(REG_INT_LEVEL, 32'h4);
    u_host.wr(REG_IRQ_MASK, 32'h1F);
    ex(K_GENERIC, HOST_INTERRUPT_OP, 4'h0, 12'h010, 8'h00, 13'h0000);
    u_host.rd(REG_IRQ_STAT, rd);
    chk("host_interrupt_op_lvl0", 32'h0, rd);
    ex(K_GENERIC, HOST_INTERRUPT_OP, 4'h1, 12'h010, 8'h00, 13'h0000);
    chk("host_interrupt_op_pc", 32'h011, res.pc);
    u_host.rd(REG_IRQ_STAT, rd);
    chk("host_interrupt_op_stat", 32'h2, rd);
    chk("irq_on", 32'h1, {31'h0, irq});
    u_host.wr(REG_IRQ_MASK, 32'h0);
    u_host.rd(REG_IRQ_STAT, rd);
    chk("irq_masked", 32'h0, {31'h0, irq});
    u_host.wr(REG_IRQ_MASK, 32'h1F);
    u_host.wr(REG_IRQ_STAT, 32'h2);
    u_host.rd(REG_IRQ_STAT, rd);
    chk("irq_clr", 32'h0, {rd[30:0], irq});
    // Block completion, flagged then unflagged
    u_host.wr(12'h108, 32'h80);
    u_host.wr(12'h10C, 32'h00);
    u_host.wr(lta(1, 16), 32'hC3);
    u_host.wr(lta(1, 17), 32'h3C);
    ex(K_GENERIC, NEXT_BLOCK_OP, 4'h1, 12'h020, 8'h00, 13'h0000);
    u_host.rd(12'h108, rd);
    chk("blk0", 32'h01C33C00, rd);
    u_host.rd(REG_IRQ_STAT, rd);
    chk("blk0_irq", 32'h2, rd);
    u_host.wr(REG_IRQ_STAT, 32'h2);
    ex(K_GENERIC, NEXT_BLOCK_OP, 4'h1, 12'h021, 8'h00, 13'h0000);
    u_host.rd(12'h10C, rd);
    chk("blk1", 32'h01C33C00, rd);
    u_host.rd(REG_IRQ_STAT, rd);
    chk("blk1_irq", 32'h0, rd);
    // Block check over two random bytes
    crc = 16'h0000;
    for (i = 0; i < 2; i++) begin
      rv = $random(seed);
      crc = crc_step(crc, rv);
      ex(K_GENERIC, BLOCK_CHECK_OP, 4'h0, 12'h030, rv, 13'h0000);
    end
    u_host.rd(lta(0, 4), rd);
    chk("crc_lo", {24'h0, crc[7:0]}, rd);
    u_host.rd(lta(0, 5), rd);
    chk("crc_hi", {24'h0, crc[15:8]}, rd);
    // Sync hunt gates requests of its channel only
    ex(K_GENERIC, SYNC_SEARCH_OP, 4'h0, 12'h040, 8'h00, 13'h0000);
    chk("hunt", 32'h1, {28'h0, hs});
    line_req <= 4'h3;
    repeat (3) @(posedge clk);
    chk("gated", 32'h2, {28'h0, chan_req});
    u_host.rd(REG_STATE, rd);
    chk("state", 32'h00010001, rd);
    sync_det <= 4'h1;
    @(posedge clk);
    sync_det <= 4'h0;
    repeat (3) @(posedge clk);
    chk("ungated", 32'h3, {28'h0, chan_req});
    line_req <= 4'h0;
    // Soft initialize
    ex(K_GENERIC, SOFT_INITIALIZE_OP, 4'h2, 12'h050, 8'h00, 13'h0000);
    chk("soft", 32'h1, {31'h0, si});
    u_host.rd(REG_IRQ_STAT, rd);
    chk("soft_stat", 32'h10, {rd[30:0], 1'b0} >> 1);
    chk("soft_irq", 32'h1, {31'h0, irq});
    u_host.rd(12'h800, rd);
    chk("unmapped", 32'h0, rd);
    tally_and_finish();
  end
endmodule : cpg_generic_ops_tb
`default_nettype wire
